// ===== sfthc_map.svh
// Register map, field positions, reset values and sizes for the
// serial FIFO threshold configuration block.
// Assumes a 32-bit APB slave with byte addresses.
`ifndef SFTHC_MAP_SVH
`define SFTHC_MAP_SVH
`define SFTHC_OFF_RX_CFG 12'h000
`define SFTHC_OFF_TX_CFG 12'h004
`define SFTHC_OFF_SETUP 12'h008
`define SFTHC_OFF_STATUS 12'h00C
`define SFTHC_OFF_INT_STAT 12'h010
`define SFTHC_OFF_INT_MASK 12'h014
`define SFTHC_CLR_BIT 7
`define SFTHC_SEL_BIT 6
`define SFTHC_LVL_LSB 0
`define SFTHC_SETUP_ENA_BIT 0
`define SFTHC_SETUP_RXIE_BIT 2
`define SFTHC_SETUP_TXIE_BIT 3
`define SFTHC_SETUP_DPX_LSB 8
`define SFTHC_RX_CFG_RST 8'h00
`define SFTHC_TX_CFG_RST 8'h00
`define SFTHC_SETUP_RST 10'h000
`define SFTHC_HALF_DEPTH 3'd4
`define SFTHC_FULL_DEPTH 3'd2
`define SFTHC_EMPTY_LVL 3'd0
`define SFTHC_INT_RX_BIT 0
`define SFTHC_INT_TX_BIT 1
`define SFTHC_INT_STAT_RST 2'h0
`define SFTHC_INT_MASK_RST 2'h0
`define SFTHC_STAT_TXREQ_BIT 0
`define SFTHC_STAT_RXREQ_BIT 1
`define SFTHC_STAT_TXD_LSB 4
`define SFTHC_STAT_RXD_LSB 8
`endif

// ===== sfthc_pkg.sv
// Types shared by the serial FIFO threshold configuration block.
// Assumes nothing of its surroundings.
package sfthc_pkg;
   typedef enum logic [1:0] {
      SFTHC_DPX_OFF,
      SFTHC_DPX_HALF_RX,
      SFTHC_DPX_HALF_TX,
      SFTHC_DPX_FULL
   } sfthc_duplex_t;
endpackage : sfthc_pkg

// ===== sfthc_lvl_event.sv
// One FIFO's threshold event: one-cycle pulse on the selected condition.
// Assumes fill level, read strobe and threshold are synchronous to clk.
`timescale 1ns/1ns
module sfthc_lvl_event #(
   parameter int LW = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [LW-1:0] fill_level,
   input wire logic [LW-1:0] threshold,
   input wire logic read_strobe,
   input wire logic cond_select,
   input wire logic above_mode,
   input wire logic active,
   output logic event_pulse
);
   logic hit_r;
   logic hit;
   logic extra;
   assign hit = active && (fill_level == threshold);
   // Rx: content above level at a read; tx: level not equal to the threshold at a read
   assign extra = active && cond_select && read_strobe &&
      (above_mode ? (fill_level > threshold) : (fill_level != threshold));
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hit_r <= 1'b0;
      end else begin
         hit_r <= hit;
      end
   end
   assign event_pulse = (hit && !hit_r) || extra;
endmodule : sfthc_lvl_event

// ===== sfthc_top.sv
// Serial FIFO threshold configuration: clear strobes, thresholds,
// interrupt events and an APB register file.
// Assumes the FIFOs report their fill levels and read strobes on clk.
`timescale 1ns/1ns
module sfthc_top #(
   parameter int LW = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [LW-1:0] rx_fill_level,
   input wire logic [LW-1:0] tx_fill_level,
   input wire logic rx_read_strobe,
   input wire logic tx_read_strobe,
   output logic rx_fifo_clear,
   output logic tx_fifo_clear,
   output logic [LW-1:0] rx_fifo_depth,
   output logic [LW-1:0] tx_fifo_depth,
   output logic rx_int_req,
   output logic tx_int_req,
   output logic irq
);
   import sfthc_pkg::*;
`include "sfthc_map.svh"

   logic [7:0] rx_cfg_r;
   logic [7:0] tx_cfg_r;
   logic [9:0] setup_r;
   logic [1:0] int_stat_r;
   logic [1:0] int_mask_r;
   logic rx_clr_r;
   logic tx_clr_r;
   logic [LW-1:0] rx_depth_r;
   logic [LW-1:0] tx_depth_r;
   logic rx_req_r;
   logic tx_req_r;
   logic [31:0] prdata_r;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [LW-1:0] rx_thr;
   logic [LW-1:0] tx_thr;
   logic rx_ev;
   logic tx_ev;
   logic fifo_on;
   sfthc_duplex_t dpx;
   logic full_dpx;
   logic sel_rx_cfg;
   logic sel_tx_cfg;
   logic sel_setup;
   logic sel_status;
   logic sel_int_stat;
   logic sel_int_mask;
   logic wr_rx_cfg;
   logic wr_tx_cfg;
   logic wr_setup;
   logic wr_int_stat;
   logic wr_int_mask;
   logic [1:0] stat_clr;
   logic [1:0] stat_set;
   logic [31:0] status_word;
   logic [31:0] rd_word;

   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   // One select per register; any other address is refused
   assign sel_rx_cfg = (paddr == `SFTHC_OFF_RX_CFG);
   assign sel_tx_cfg = (paddr == `SFTHC_OFF_TX_CFG);
   assign sel_setup = (paddr == `SFTHC_OFF_SETUP);
   assign sel_status = (paddr == `SFTHC_OFF_STATUS);
   assign sel_int_stat = (paddr == `SFTHC_OFF_INT_STAT);
   assign sel_int_mask = (paddr == `SFTHC_OFF_INT_MASK);
   assign addr_ok = sel_rx_cfg || sel_tx_cfg || sel_setup ||
      sel_status || sel_int_stat || sel_int_mask;
   assign wr_rx_cfg = wr_en && sel_rx_cfg;
   assign wr_tx_cfg = wr_en && sel_tx_cfg;
   assign wr_setup = wr_en && sel_setup;
   assign wr_int_stat = wr_en && sel_int_stat;
   assign wr_int_mask = wr_en && sel_int_mask;
   assign pslverr = psel && penable && !addr_ok;

   assign fifo_on = setup_r[`SFTHC_SETUP_ENA_BIT];
   assign dpx = sfthc_duplex_t'(setup_r[`SFTHC_SETUP_DPX_LSB +: 2]);
   assign full_dpx = (dpx == SFTHC_DPX_FULL);

   // Receive configuration; the clear bit is a strobe, never stored
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_cfg_r <= `SFTHC_RX_CFG_RST;
      end else if (wr_rx_cfg) begin
         rx_cfg_r <= {1'b0, pwdata[`SFTHC_SEL_BIT], 4'h0,
            pwdata[`SFTHC_LVL_LSB +: 2]};
      end
   end

   // Transmit configuration, same layout as receive
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_cfg_r <= `SFTHC_TX_CFG_RST;
      end else if (wr_tx_cfg) begin
         tx_cfg_r <= {1'b0, pwdata[`SFTHC_SEL_BIT], 4'h0,
            pwdata[`SFTHC_LVL_LSB +: 2]};
      end
   end

   // FIFO setup: enable, interrupt enables and duplex code
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         setup_r <= `SFTHC_SETUP_RST;
      end else if (wr_setup) begin
         setup_r <= {pwdata[`SFTHC_SETUP_DPX_LSB +: 2], 4'h0,
            pwdata[`SFTHC_SETUP_TXIE_BIT], pwdata[`SFTHC_SETUP_RXIE_BIT],
            1'b0, pwdata[`SFTHC_SETUP_ENA_BIT]};
      end
   end

   // Interrupt mask, same layout as the status bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_mask_r <= `SFTHC_INT_MASK_RST;
      end else if (wr_int_mask) begin
         int_mask_r <= pwdata[1:0];
      end
   end

   // One-cycle clear strobes toward the FIFOs, the cycle after the write
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_clr_r <= 1'b0;
      end else begin
         rx_clr_r <= wr_rx_cfg && pwdata[`SFTHC_CLR_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_clr_r <= 1'b0;
      end else begin
         tx_clr_r <= wr_tx_cfg && pwdata[`SFTHC_CLR_BIT];
      end
   end
   assign rx_fifo_clear = rx_clr_r;
   assign tx_fifo_clear = tx_clr_r;

   // FIFO sizing from duplex setting
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_depth_r <= '0;
         tx_depth_r <= '0;
      end else if (!fifo_on) begin
         rx_depth_r <= '0;
         tx_depth_r <= '0;
      end else begin
         case (dpx)
            SFTHC_DPX_HALF_RX: begin
               rx_depth_r <= LW'(`SFTHC_HALF_DEPTH);
               tx_depth_r <= '0;
            end
            SFTHC_DPX_HALF_TX: begin
               rx_depth_r <= '0;
               tx_depth_r <= LW'(`SFTHC_HALF_DEPTH);
            end
            SFTHC_DPX_FULL: begin
               rx_depth_r <= LW'(`SFTHC_FULL_DEPTH);
               tx_depth_r <= LW'(`SFTHC_FULL_DEPTH);
            end
            default: begin
               rx_depth_r <= '0;
               tx_depth_r <= '0;
            end
         endcase
      end
   end
   assign rx_fifo_depth = rx_depth_r;
   assign tx_fifo_depth = tx_depth_r;

   // Threshold decode
   always_comb begin
      rx_thr = '0;
      case (rx_cfg_r[1:0])
         2'b00: rx_thr = full_dpx ? LW'(2) : LW'(4);
         2'b01: rx_thr = LW'(1);
         2'b10: rx_thr = LW'(2);
         2'b11: rx_thr = full_dpx ? LW'(1) : LW'(3);
         default: rx_thr = '0;
      endcase
   end

   always_comb begin
      tx_thr = '0;
      case (tx_cfg_r[1:0])
         2'b00: tx_thr = LW'(`SFTHC_EMPTY_LVL);
         2'b01: tx_thr = LW'(1);
         2'b10: tx_thr = full_dpx ? LW'(`SFTHC_EMPTY_LVL) : LW'(2);
         2'b11: tx_thr = full_dpx ? LW'(1) : LW'(3);
         default: tx_thr = '0;
      endcase
   end

   sfthc_lvl_event #(.LW(LW)) u_rx_ev (
      .clk(clk),
      .rst_b(rst_b),
      .fill_level(rx_fill_level),
      .threshold(rx_thr),
      .read_strobe(rx_read_strobe),
      .cond_select(rx_cfg_r[`SFTHC_SEL_BIT]),
      .above_mode(1'b1),
      .active(fifo_on),
      .event_pulse(rx_ev)
   );

   sfthc_lvl_event #(.LW(LW)) u_tx_ev (
      .clk(clk),
      .rst_b(rst_b),
      .fill_level(tx_fill_level),
      .threshold(tx_thr),
      .read_strobe(tx_read_strobe),
      .cond_select(tx_cfg_r[`SFTHC_SEL_BIT]),
      .above_mode(1'b0),
      .active(fifo_on),
      .event_pulse(tx_ev)
   );

   // Interrupt requests: one-cycle pulses, each gated by its enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_req_r <= 1'b0;
      end else begin
         rx_req_r <= rx_ev && setup_r[`SFTHC_SETUP_RXIE_BIT];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_req_r <= 1'b0;
      end else begin
         tx_req_r <= tx_ev && setup_r[`SFTHC_SETUP_TXIE_BIT];
      end
   end
   assign rx_int_req = rx_req_r;
   assign tx_int_req = tx_req_r;

   // Sticky status, write one to clear; a new event wins over the clear
   assign stat_set = {tx_req_r, rx_req_r};
   assign stat_clr = wr_int_stat ? pwdata[1:0] : 2'h0;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         int_stat_r <= `SFTHC_INT_STAT_RST;
      end else begin
         int_stat_r <= (int_stat_r & ~stat_clr) | stat_set;
      end
   end
   assign irq = |(int_stat_r & int_mask_r);

   // Status word: live FIFO sizes and the request pulses
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SFTHC_STAT_RXD_LSB +: 3] = 3'(rx_depth_r);
      status_word[`SFTHC_STAT_TXD_LSB +: 3] = 3'(tx_depth_r);
      status_word[`SFTHC_STAT_RXREQ_BIT] = rx_req_r;
      status_word[`SFTHC_STAT_TXREQ_BIT] = tx_req_r;
   end

   // Read mux; clear bits are never stored, so they read back zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `SFTHC_OFF_RX_CFG: rd_word = 32'(rx_cfg_r);
         `SFTHC_OFF_TX_CFG: rd_word = 32'(tx_cfg_r);
         `SFTHC_OFF_SETUP: rd_word = 32'(setup_r);
         `SFTHC_OFF_STATUS: rd_word = status_word;
         `SFTHC_OFF_INT_STAT: rd_word = 32'(int_stat_r);
         `SFTHC_OFF_INT_MASK: rd_word = 32'(int_mask_r);
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Read data, registered in the setup cycle so it stands at access
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= rd_word;
      end
   end
   assign prdata = rd_en ? prdata_r : 32'h0000_0000;
endmodule : sfthc_top

// ===== sfthc_properties.sv
// Port checker for sfthc_top: clear strobes, read-back, FIFO sizing.
// Assumes a zero-wait APB slave; bound to every sfthc_top instance.
`timescale 1ns/1ns
module sfthc_properties #(
   parameter int LW = 3
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic rx_fifo_clear,
   input wire logic tx_fifo_clear,
   input wire logic [LW-1:0] rx_fifo_depth,
   input wire logic [LW-1:0] tx_fifo_depth,
   input wire logic rx_int_req,
   input wire logic tx_int_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic wr_c;
   logic rd_c;
   assign wr_c = psel && penable && pwrite && pwdata[7];
   assign rd_c = psel && penable && !pwrite;
   a_rx_clr_set: assert property (
      wr_c && paddr == 12'h000 |=> rx_fifo_clear)
      else $error("rx clear strobe missing");
   a_rx_clr_src: assert property (
      rx_fifo_clear |-> $past(wr_c && paddr == 12'h000))
      else $error("rx clear strobe without write");
   a_tx_clr_set: assert property (
      wr_c && paddr == 12'h004 |=> tx_fifo_clear)
      else $error("tx clear strobe missing");
   a_tx_clr_src: assert property (
      tx_fifo_clear |-> $past(wr_c && paddr == 12'h004))
      else $error("tx clear strobe without write");
   a_clr_one_cycle: assert property (
      $rose(rx_fifo_clear || tx_fifo_clear)
      |=> !rx_fifo_clear && !tx_fifo_clear)
      else $error("clear strobe too long");
   a_clr_reads_zero: assert property (rd_c && paddr[11:3] == 9'h000
      |-> prdata[31:7] == 25'h0) else $error("clear bit read as one");
   a_depth_split: assert property (rx_fifo_depth != 3'd0
      |-> tx_fifo_depth == 3'd4 - rx_fifo_depth) else $error("bad FIFO split");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h014
      |-> pslverr) else $error("unmapped access not refused");
   c_rx_req: cover property (rx_int_req);
   c_tx_req: cover property (tx_int_req);
   c_rx_clr: cover property (rx_fifo_clear);
endmodule : sfthc_properties

bind sfthc_top sfthc_properties #(.LW(LW)) u_sfthc_properties (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pslverr(pslverr), .rx_fifo_clear(rx_fifo_clear),
   .tx_fifo_clear(tx_fifo_clear), .rx_fifo_depth(rx_fifo_depth),
   .tx_fifo_depth(tx_fifo_depth), .rx_int_req(rx_int_req),
   .tx_int_req(tx_int_req));

// ===== sfthc_top_bench.sv
// Self-checking bench for sfthc_top: registers, sizing, thresholds, irq.
// Assumes the default LW of 3; reads are scored from a queue.
`timescale 1ns/1ns
module sfthc_top_bench;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] rx_fill, tx_fill, rx_dep, tx_dep, hit, r;
   logic rx_stb, tx_stb, rx_req, tx_req, irq;
   int bad_count, tests_run, seed;
   logic [32:0] exp_q[$];
   // Three bits per code, code 0 lowest
   logic [11:0] rxd = {3'd2, 3'd0, 3'd4, 3'd0};
   logic [11:0] txd = {3'd2, 3'd4, 3'd0, 3'd0};
   logic [11:0] hr = {3'd3, 3'd2, 3'd1, 3'd4};
   logic [11:0] fr = {3'd1, 3'd2, 3'd1, 3'd2};
   logic [11:0] ht = {3'd3, 3'd2, 3'd1, 3'd0};
   logic [11:0] ft = {3'd1, 3'd0, 3'd1, 3'd0};
   sfthc_top u_sfthc_top (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_fill_level(rx_fill),
      .tx_fill_level(tx_fill), .rx_read_strobe(rx_stb),
      .tx_read_strobe(tx_stb), .rx_fifo_clear(),
      .tx_fifo_clear(), .rx_fifo_depth(rx_dep),
      .tx_fifo_depth(tx_dep), .rx_int_req(rx_req),
      .tx_int_req(tx_req), .irq(irq));
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   task automatic apb(input logic [11:0] a, input logic w,
         input logic [9:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {22'h0, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16) begin
         @(posedge clk);
         n++;
      end
      if (n == 16) begin
         bad_count++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [9:0] e,
         input logic err);
      exp_q.push_back({err, 22'h0, e});
      apb(a, 1'b0, 10'h000);
   endtask : rd
   // Steps one fill level and notes the level whose request fired
   task automatic sweep(input logic tx);
      hit = 3'd7;
      for (int v = 1; v < 5; v++) begin
         if (tx) tx_fill <= 3'(4 - v);
         else rx_fill <= 3'(v);
         repeat (3) begin
            @(posedge clk);
            if ((tx ? tx_req : rx_req) === 1'b1 && hit == 3'd7) begin
               hit = tx ? 3'(4 - v) : 3'(v);
            end
         end
      end
      rx_fill <= 3'd0;
      tx_fill <= 3'd7;
      @(posedge clk);
   endtask : sweep
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         chk({pslverr, prdata}, exp_q.pop_front());
      end
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      bad_count++;
      summarize();
   end
   initial begin
      {psel, penable, pwrite, rx_stb, tx_stb, rst_b} = 6'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      rx_fill = 3'd0;
      tx_fill = 3'd7;
      bad_count = 0;
      tests_run = 0;
      seed = 32'h0cae_528c;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(12'h000, 10'h000, 1'b0);
      rd(12'h004, 10'h000, 1'b0);
      rd(12'h020, 10'h000, 1'b1);
      wr_cfg: begin
         apb(12'h008, 1'b1, 10'h30d);
         apb(12'h000, 1'b1, 10'h0c3);
         rd(12'h000, 10'h043, 1'b0);
         apb(12'h004, 1'b1, 10'h0c2);
         rd(12'h004, 10'h042, 1'b0);
      end
      for (int d = 0; d < 4; d++) begin
         apb(12'h008, 1'b1, {2'(d), 8'h0d});
         @(negedge clk);
         chk(33'({rx_dep, tx_dep}), 33'({rxd[3*d+:3], txd[3*d+:3]}));
         @(posedge clk);
      end
      apb(12'h008, 1'b1, 10'h300);
      @(negedge clk);
      chk(33'({rx_dep, tx_dep}), 33'h0);
      @(posedge clk);
      for (int m = 0; m < 2; m++) begin
         for (int l = 0; l < 4; l++) begin
            apb(12'h008, 1'b1, m ? 10'h30d : 10'h10d);
            apb(12'h000, 1'b1, 10'(l));
            sweep(1'b0);
            chk(33'(hit), 33'(m ? fr[3*l+:3] : hr[3*l+:3]));
            apb(12'h008, 1'b1, m ? 10'h30d : 10'h20d);
            apb(12'h004, 1'b1, 10'(l));
            sweep(1'b1);
            chk(33'(hit), 33'(m ? ft[3*l+:3] : ht[3*l+:3]));
         end
      end
      apb(12'h008, 1'b1, 10'h109);
      apb(12'h000, 1'b1, 10'h001);
      sweep(1'b0);
      chk(33'(hit), 33'h7);
      apb(12'h008, 1'b1, 10'h30d);
      apb(12'h010, 1'b1, 10'h003);
      apb(12'h014, 1'b1, 10'h001);
      r = 3'd2 + 3'($random(seed) & 1);
      rx_fill <= r;
      for (int s = 0; s < 2; s++) begin
         apb(12'h000, 1'b1, s ? 10'h041 : 10'h001);
         rx_stb <= 1'b1;
         @(posedge clk);
         rx_stb <= 1'b0;
         repeat (4) @(posedge clk);
         rd(12'h010, 10'(s), 1'b0);
      end
      chk(33'(irq), 33'h1);
      apb(12'h014, 1'b1, 10'h000);
      chk(33'(irq), 33'h0);
      apb(12'h014, 1'b1, 10'h001);
      apb(12'h010, 1'b1, 10'h001);
      chk(33'(irq), 33'h0);
      apb(12'h008, 1'b1, 10'h20d);
      apb(12'h004, 1'b1, 10'h042);
      tx_fill <= 3'($random(seed) & 1);
      tx_stb <= 1'b1;
      @(posedge clk);
      tx_stb <= 1'b0;
      repeat (4) @(posedge clk);
      rd(12'h010, 10'h002, 1'b0);
      summarize();
   end
endmodule : sfthc_top_bench
